//--- pe_regs.svh
`ifndef PE_REGS_SVH
`define PE_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PE_IDX_INPUT     6'h00
`define PE_IDX_OUTPUT    6'h01
`define PE_IDX_POLARITY  6'h02
`define PE_IDX_CONFIG    6'h03
`define PE_IDX_STATUS    6'h04
`define PE_IDX_MASK      6'h05

// ==========================================================
// Reset values
`define PE_RST_INPUT     8'hFF
`define PE_RST_OUTPUT    8'hFF
`define PE_RST_POLARITY  8'h00
`define PE_RST_CONFIG    8'hFF
`define PE_RST_STATUS    8'h00
`define PE_RST_MASK      8'h00

// ==========================================================
// Field positions and responses
`define PE_STAT_CHANGE   0
`define PE_RESP_OKAY     2'h0
`define PE_RESP_SLVERR   2'h2

`endif

//--- pe_pkg.sv
package pe_pkg;

	// ==========================================================
	// Software-visible port settings
	typedef struct packed {
		logic [7:0] out_lvl;
		logic [7:0] pol_inv;
		logic [7:0] dir_in;
	} pe_cfg_t;

	// ==========================================================
	// Power-on sequencing
	typedef enum logic [0:0] {
		PE_ST_INIT,
		PE_ST_RUN
	} pe_state_t;

endpackage

//--- pe_top.sv
`include "pe_regs.svh"

// Summary of operation
// - Any input-configured pin changing level raises the interrupt; output pins never do.
// - Interrupt line is active low open drain: pulled low when asserted, else released.
// - Interrupt line drops when changed inputs return to their earlier levels.
// - Reading the input port register drops the interrupt line.
// - Switching a pin to input with a differing level raises an interrupt.
// - During reset all but the pin synchroniser is held; on release state machine and registers start from defaults.
// - Input port register shows polarity-adjusted levels of all eight pins in any direction.
// - Configuration bit set makes pin an input, driver off; cleared drives it.
// - Polarity bit set returns the inverted pin level in the input port.
module pe_top
	import pe_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Port pins
	input  wire logic [7:0]  io_in,
	output logic [7:0]       io_out,
	output logic [7:0]       io_oe_n,
	// Open-drain interrupt line and system interrupt
	output logic             irq_n_out,
	output logic             irq_n_out_oe_n,
	output logic             irq
);

	// ==========================================================
	// Pin synchroniser
	logic [7:0] pin_meta_reg;
	logic [7:0] pin_sync_reg;

	// Free-running, so the snapshot at release sees true pins
	// A reset here would seed the snapshot with ones, not the pins
	always_ff @(posedge clk) begin
		pin_meta_reg <= io_in;
		pin_sync_reg <= pin_meta_reg;
	end

	// ==========================================================
	// Bus handshake state
	logic       aw_have_reg, aw_have_next;
	logic       w_have_reg, w_have_next;
	logic [5:0] aw_idx_reg, aw_idx_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic       wlane_reg, wlane_next;
	logic       bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic       awready_reg, awready_next;
	logic       wready_reg, wready_next;
	logic       arready_reg, arready_next;
	logic       rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [7:0] rdata_reg, rdata_next;
	logic       wr_fire;
	logic       rd_fire;
	logic [5:0] rd_idx;
	logic       in_read;
	logic       stat_read;

	// ==========================================================
	// Block state
	pe_cfg_t    cfg_reg, cfg_next;
	pe_state_t  st_reg, st_next;
	logic [7:0] ref_reg, ref_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] mask_reg, mask_next;
	logic       chg_reg, chg_next;
	logic       drive_reg, drive_next;
	logic       irq_reg, irq_next;
	logic [7:0] mismatch;
	logic [7:0] in_view;

	// Write acts once both halves are held
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && arready_reg;
	assign rd_idx = s_axi_araddr[7:2];
	assign in_read = rd_fire && (rd_idx == `PE_IDX_INPUT);
	assign stat_read = rd_fire && (rd_idx == `PE_IDX_STATUS);
	// Pins sampled raw, all directions, then inverted per bit
	assign in_view = pin_sync_reg ^ cfg_reg.pol_inv;

	// ==========================================================
	// Write channel
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_idx_next = aw_idx_reg;
		wbyte_next = wbyte_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			aw_idx_next = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			// Input port accepts writes and ignores them
			if (aw_idx_reg <= `PE_IDX_MASK) begin
				bresp_next = `PE_RESP_OKAY;
			end else begin
				bresp_next = `PE_RESP_SLVERR;
			end
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// One write in flight keeps the decode simple
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `PE_RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_idx_reg <= aw_idx_next;
			wbyte_reg <= wbyte_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
		end
	end

	// ==========================================================
	// Read channel
	always_comb begin
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		// Read side effects act at the taking edge
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = `PE_RESP_OKAY;
			case (rd_idx)
				`PE_IDX_INPUT: rdata_next = in_view;
				`PE_IDX_OUTPUT: rdata_next = cfg_reg.out_lvl;
				`PE_IDX_POLARITY: rdata_next = cfg_reg.pol_inv;
				`PE_IDX_CONFIG: rdata_next = cfg_reg.dir_in;
				`PE_IDX_STATUS: rdata_next = status_reg;
				`PE_IDX_MASK: rdata_next = mask_reg;
				default: begin
					rdata_next = 8'h00;
					rresp_next = `PE_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `PE_RESP_OKAY;
			rdata_reg <= 8'h00;
			arready_reg <= 1'b0;
		end else begin
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			arready_reg <= arready_next;
		end
	end

	// ==========================================================
	// Port settings, snapshot and change detection
	// Raw levels compared, so polarity never fakes a change
	assign mismatch = (st_reg == PE_ST_RUN) ?
		((pin_sync_reg ^ ref_reg) & cfg_reg.dir_in) : 8'h00;

	always_comb begin
		cfg_next = cfg_reg;
		ref_next = ref_reg;
		st_next = st_reg;
		mask_next = mask_reg;
		if (wr_fire && wlane_reg) begin
			case (aw_idx_reg)
				`PE_IDX_OUTPUT: cfg_next.out_lvl = wbyte_reg;
				`PE_IDX_POLARITY: cfg_next.pol_inv = wbyte_reg;
				`PE_IDX_CONFIG: cfg_next.dir_in = wbyte_reg;
				`PE_IDX_MASK: mask_next = wbyte_reg & 8'h01;
				default: mask_next = mask_reg;
			endcase
		end
		case (st_reg)
			PE_ST_INIT: begin
				// First clocked sample after release seeds the snapshot
				ref_next = pin_sync_reg;
				st_next = PE_ST_RUN;
			end
			PE_ST_RUN: begin
				if (in_read) begin
					ref_next = pin_sync_reg;
				end
			end
			default: st_next = PE_ST_INIT;
		endcase
		chg_next = |mismatch;
		drive_next = |mismatch;
		// Set wins over the read that clears
		status_next = status_reg;
		if (stat_read) begin
			status_next = 8'h00;
		end
		if (chg_next && !chg_reg) begin
			status_next[`PE_STAT_CHANGE] = 1'b1;
		end
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= '{`PE_RST_OUTPUT, `PE_RST_POLARITY, `PE_RST_CONFIG};
			ref_reg <= `PE_RST_INPUT;
			st_reg <= PE_ST_INIT;
			status_reg <= `PE_RST_STATUS;
			mask_reg <= `PE_RST_MASK;
			chg_reg <= 1'b0;
			drive_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			ref_reg <= ref_next;
			st_reg <= st_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			chg_reg <= chg_next;
			drive_reg <= drive_next;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================
	// Outputs
	// Bus outputs straight from registers
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign io_out = cfg_reg.out_lvl;
	assign io_oe_n = cfg_reg.dir_in;
	// Line only ever pulled low, never driven high
	assign irq_n_out = 1'b0;
	assign irq_n_out_oe_n = !drive_reg;
	// System interrupt gated by the mask, line is not
	assign irq = irq_reg;

endmodule

//--- pe_irq_host.sv
module pe_irq_host(
	// Open-drain interrupt pin
	input  wire logic irq_n_out,
	input  wire logic irq_n_out_oe_n,
	// Line seen by the bus master
	output logic      irq_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up holds the line high once released
	assign irq_line = irq_n_out_oe_n ? 1'b1 : irq_n_out;
endmodule

//--- pe_top_checker.sv
module pe_top_checker(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Watched ports
	input  wire logic [7:0]  io_in,
	input  wire logic [7:0]  io_out,
	input  wire logic [7:0]  io_oe_n,
	input  wire logic        irq_n_out,
	input  wire logic        irq_n_out_oe_n,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_bvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Cycles since pins or directions last moved
	logic [3:0]  quiet_reg, quiet_next;
	logic [15:0] prev_reg;
	always_comb begin
		quiet_next = (quiet_reg == 4'hF) ? 4'hF : quiet_reg + 4'h1;
		if (prev_reg != {io_in, io_oe_n})
			quiet_next = 4'h0;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiet_reg <= 4'h0;
			prev_reg <= 16'h0;
		end else begin
			quiet_reg <= quiet_next;
			prev_reg <= {io_in, io_oe_n};
		end
	end
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	od_data_a: assert property (!irq_n_out)
		else $error("interrupt data bit not low");
	rst_dflt_a: assert property ($rose(rstn) |-> io_oe_n == 8'hFF && io_out == 8'hFF
		&& irq_n_out_oe_n) else $error("outputs not at defaults after reset");
	dir_wr_a: assert property ($changed(io_oe_n) |-> $rose(s_axi_bvalid))
		else $error("pin direction moved without a write");
	lvl_wr_a: assert property ($changed(io_out) |-> $rose(s_axi_bvalid))
		else $error("pin level moved without a write");
	rd_hi_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	rd_clr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00
		|-> ##[1:4] irq_n_out_oe_n) else $error("input read left interrupt asserted");
	cause_a: assert property ($fell(irq_n_out_oe_n) |-> quiet_reg < 4'h8)
		else $error("interrupt without pin or direction change");
	out_only_a: assert property ((io_oe_n == 8'h00)[*6] |-> irq_n_out_oe_n)
		else $error("interrupt while all pins are outputs");
endmodule

bind pe_top pe_top_checker i_chk (
	.clk            (clk),
	.rstn           (rstn),
	.io_in          (io_in),
	.io_out         (io_out),
	.io_oe_n        (io_oe_n),
	.irq_n_out      (irq_n_out),
	.irq_n_out_oe_n (irq_n_out_oe_n),
	.s_axi_arvalid  (s_axi_arvalid),
	.s_axi_arready  (s_axi_arready),
	.s_axi_araddr   (s_axi_araddr),
	.s_axi_rvalid   (s_axi_rvalid),
	.s_axi_rdata    (s_axi_rdata),
	.s_axi_bvalid   (s_axi_bvalid)
);

//--- pe_top_tb.sv
module pe_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, irq_n_out, irq_n_out_oe_n, irq, irq_line;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, io_in, io_out, io_oe_n;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	int          miscompares, tests_run;
	pe_top i_dut (
		.clk            (clk),
		.rstn           (rstn),
		.s_axi_awaddr   (s_axi_awaddr),
		.s_axi_awvalid  (s_axi_awvalid),
		.s_axi_awready  (s_axi_awready),
		.s_axi_wdata    (s_axi_wdata),
		.s_axi_wstrb    (s_axi_wstrb),
		.s_axi_wvalid   (s_axi_wvalid),
		.s_axi_wready   (s_axi_wready),
		.s_axi_bresp    (s_axi_bresp),
		.s_axi_bvalid   (s_axi_bvalid),
		.s_axi_bready   (s_axi_bready),
		.s_axi_araddr   (s_axi_araddr),
		.s_axi_arvalid  (s_axi_arvalid),
		.s_axi_arready  (s_axi_arready),
		.s_axi_rdata    (s_axi_rdata),
		.s_axi_rresp    (s_axi_rresp),
		.s_axi_rvalid   (s_axi_rvalid),
		.s_axi_rready   (s_axi_rready),
		.io_in          (io_in),
		.io_out         (io_out),
		.io_oe_n        (io_oe_n),
		.irq_n_out      (irq_n_out),
		.irq_n_out_oe_n (irq_n_out_oe_n),
		.irq            (irq)
	);
	pe_irq_host i_host (
		.irq_n_out      (irq_n_out),
		.irq_n_out_oe_n (irq_n_out_oe_n),
		.irq_line       (irq_line)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Generous margin over the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done;
	end
	// ==========
	// Shared tasks
	task automatic chk(input string n, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, v);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!hb) begin
			@(negedge clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) s_axi_bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ha, hr;
		hr = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!hr) begin
			@(negedge clk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) s_axi_rready <= 1'b0;
		end
	endtask
	task automatic pin(input logic [7:0] v);
		@(posedge clk);
		io_in <= v;
	endtask
	// Sync stages delay the line by a few clocks
	task automatic wl(input logic e);
		for (int i = 0; i < 12 && irq_line !== e; i++) @(negedge clk);
		chk("irq line", {7'h0, irq_line}, {7'h0, e});
	endtask
	// ==========
	// Scenarios
	task automatic t_reset;
		logic [7:0] rv [6] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
		chk("pin enables", io_oe_n, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk("reset value", d[7:0], rv[i]);
		end
		rd(8'h18, d, r);
		chk("unmapped resp", {6'h0, r}, 8'h02);
		wr(8'h00, 8'h00);
		chk("input write resp", {6'h0, r}, 8'h00);
		rd(8'h00, d, r);
		chk("input port", d[7:0], 8'hFF);
		wr(8'h18, 8'h00);
		chk("unmapped wr resp", {6'h0, r}, 8'h02);
		$display("reset test done");
	endtask
	task automatic t_change;
		pin(8'hF7);
		wl(1'b0);
		pin(8'hFF);
		wl(1'b1);
		rd(8'h10, d, r);
		chk("status", d[7:0], 8'h01);
		wr(8'h14, 8'h01);
		pin(8'hBF);
		wl(1'b0);
		chk("sys irq", {7'h0, irq}, 8'h01);
		rd(8'h10, d, r);
		repeat (2) @(negedge clk);
		chk("sys irq", {7'h0, irq}, 8'h00);
		pin(8'hFF);
		wl(1'b1);
		$display("change test done");
	endtask
	task automatic t_clear;
		pin(8'h5A);
		wl(1'b0);
		rd(8'h00, d, r);
		chk("input port", d[7:0], 8'h5A);
		wl(1'b1);
		wr(8'h08, 8'h0F);
		rd(8'h00, d, r);
		chk("inverted input", d[7:0], 8'h55);
		$display("clear test done");
	endtask
	task automatic t_dir;
		wr(8'h0C, 8'hF0);
		chk("pin enables", io_oe_n, 8'hF0);
		wr(8'h04, 8'h3C);
		chk("pin levels", io_out, 8'h3C);
		s_axi_wstrb <= 4'hE;
		wr(8'h04, 8'h00);
		chk("strobe off levels", io_out, 8'h3C);
		s_axi_wstrb <= 4'hF;
		pin(8'h5B);
		repeat (10) @(negedge clk);
		chk("irq line", {7'h0, irq_line}, 8'h01);
		wr(8'h0C, 8'hFF);
		wl(1'b0);
		rd(8'h00, d, r);
		chk("input port", d[7:0], 8'h54);
		wl(1'b1);
		wr(8'h0C, 8'h00);
		pin(8'h00);
		repeat (10) @(negedge clk);
		chk("irq line", {7'h0, irq_line}, 8'h01);
		wr(8'h0C, 8'hFF);
		wl(1'b0);
		$display("direction test done");
	endtask
	// Reset in mid-run with the interrupt asserted and pins low
	task automatic t_por;
		wr(8'h0C, 8'h0F);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		chk("pin enables", io_oe_n, 8'hFF);
		chk("pin levels", io_out, 8'hFF);
		repeat (10) @(negedge clk);
		chk("irq line", {7'h0, irq_line}, 8'h01);
		chk("sys irq", {7'h0, irq}, 8'h00);
		rd(8'h08, d, r);
		chk("polarity", d[7:0], 8'h00);
		rd(8'h10, d, r);
		chk("status", d[7:0], 8'h00);
		rd(8'h14, d, r);
		chk("mask", d[7:0], 8'h00);
		rd(8'h00, d, r);
		chk("input port", d[7:0], 8'h00);
		$display("power-on test done");
	endtask
	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		io_in = 8'hFF;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_change;
		t_clear;
		t_dir;
		t_por;
		test_done;
	end
endmodule
